// ---- include/fanp_pkg.sv ----
// Constants, register map and link-side carriers for the fiber
// next-page register bank.
// Assumes an AHB-Lite master with 32-bit data and one clock domain.
package fanp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] FANP_IDX_EXPANSION = 6'h06;
  localparam logic [5:0] FANP_IDX_NP_TX     = 6'h07;
  localparam logic [5:0] FANP_IDX_LP_NP     = 6'h08;
  localparam logic [5:0] FANP_IDX_EXT_STAT  = 6'h0F;
  localparam logic [5:0] FANP_IDX_CTRL_ONE  = 6'h10;

  // Fiber mode encodings
  localparam logic [1:0] FANP_MODE_FX      = 2'h0;
  localparam logic [1:0] FANP_MODE_1000X   = 2'h1;

  // Field positions
  localparam int FANP_NP_BIT       = 15;
  localparam int FANP_TOGGLE_BIT   = 11;
  localparam int FANP_CTRL_BLK_EXT = 13;
  localparam int FANP_CTRL_CRS_TX  = 11;
  localparam int FANP_CTRL_FORCE   = 10;

  // Reset values, write and retain masks, match count
  localparam logic [15:0] FANP_NP_TX_RST   = 16'h2001;
  localparam logic [15:0] FANP_CTRL_RST    = 16'h4000;
  localparam logic [15:0] FANP_NP_TX_WMASK = 16'hB7FF;
  localparam logic [15:0] FANP_CTRL_WMASK  = 16'hFE00;
  localparam logic [15:0] FANP_CTRL_RETAIN = 16'hEE00;
  localparam logic [1:0]  FANP_MATCH_NEED  = 2'h3;

  localparam logic [1:0] FANP_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] FANP_HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic [1:0]  mode;
    logic        link_ok;
    logic        sync;
    logic        an_en;
    logic        cfg_valid;
    logic [15:0] cfg_word;
    logic        page_valid;
    logic        page_next;
    logic [15:0] page_word;
    logic        full_dup;
    logic        tx_active;
    logic        rx_ext;
    logic        rx_ext_err;
  } fanp_link_in_s;

  typedef struct packed {
    logic        link_up;
    logic        crs;
    logic        rx_ext;
    logic        rx_ext_err;
    logic        np_loaded;
    logic [15:0] np_word;
  } fanp_link_out_s;

endpackage : fanp_pkg

// ---- test/fanp_link_model.sv ----
// Link partner model feeding the fiber next-page register bank.
// Assumes the bench steers it through a request struct on i_core_clk.
`timescale 1ns/100ps
`default_nettype none

module fanp_link_model
  import fanp_pkg::*;
(
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst_n,
  input  wire fanp_pkg::fanp_link_in_s i_req,
  output var  fanp_pkg::fanp_link_in_s o_link
);
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_link <= '0;
    end else begin
      o_link <= i_req;
      // Released words never keep their last value
      if (!i_req.page_valid) begin
        o_link.page_word <= ~o_link.page_word;
      end
      if (!i_req.cfg_valid) begin
        o_link.cfg_word <= ~o_link.cfg_word;
      end
    end
  end
endmodule : fanp_link_model

`default_nettype wire

// ---- test/fanp_regs_tb_top.sv ----
// Self-checking bench for the fiber next-page register bank.
// Assumes the AHB-Lite slave is the only one on the bus.
`timescale 1ns/100ps
`default_nettype none

module fanp_regs_tb_top;
  import fanp_pkg::*;
  logic           clk, rst_n, sw_rst, hsel, hwrite, hready, hresp;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic [31:0]    haddr, hwdata, hrdata, rv;
  fanp_link_in_s  rq, lnk;
  fanp_link_out_s lo;
  int             fail_count, n_compared;
  logic [31:0]    ra [6] = '{32'h18, 32'h1C, 32'h20, 32'h3C, 32'h40, 32'h44};
  logic [31:0]    re [6] = '{32'h4, 32'h2001, 32'h0, 32'hC000, 32'h4001, 32'h0};

  fanp_regs dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_sw_rst(sw_rst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_link(lnk), .o_link(lo));
  fanp_link_model part_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_req(rq),
    .o_link(lnk));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic final_report;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Bounded wait for hready at a rising edge
  task automatic rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        final_report;
      end
      @(posedge clk);
    end
  endtask : rdy

  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= FANP_HTRANS_NONSEQ;
    hwrite <= w;
    rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy;
    rv = hrdata;
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask : rd

  task automatic strobe(input logic pg, input logic nx,
                        input logic [15:0] w);
    if (pg) begin
      rq.page_valid <= 1'b1;
      rq.page_next  <= nx;
      rq.page_word  <= w;
    end else begin
      rq.cfg_valid <= 1'b1;
      rq.cfg_word  <= w;
    end
    tick(1);
    rq.page_valid <= 1'b0;
    rq.cfg_valid  <= 1'b0;
    tick(3);
  endtask : strobe

  initial begin
    rst_n = 1'b0; sw_rst = 1'b0; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    rq = '0; rq.mode = FANP_MODE_1000X; rq.link_ok = 1'b1;
    fail_count = 0; n_compared = 0;
    tick(3);
    rst_n <= 1'b1;
    tick(3);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], re[i], "reset row");
    end
    bus(1'b1, 32'h1C, 32'hFFFF);
    tick(1);
    chk("np_loaded", 32'h1, {31'h0, lo.np_loaded});
    chk("np_word", 32'hB7FF, {16'h0, lo.np_word});
    rd(32'h1C, 32'hB7FF, "np_tx");
    strobe(1'b1, 1'b1, 16'h5123);
    rd(32'h20, 32'h5123, "lp_np");
    rd(32'h1C, 32'hBFFF, "np_tx toggle");
    rd(32'h18, 32'h6, "expansion");
    rd(32'h18, 32'h4, "expansion cleared");
    strobe(1'b1, 1'b0, 16'h8001);
    rd(32'h18, 32'hE, "expansion base");
    rd(32'h20, 32'h5123, "lp_np kept");
    rq.link_ok <= 1'b0;
    tick(3);
    rd(32'h18, 32'h4, "expansion down");
    rd(32'h20, 32'h0, "lp_np down");
    chk("link_up", 32'h0, {31'h0, lo.link_up});
    bus(1'b1, 32'h40, 32'h4400);
    tick(2);
    chk("forced link_up", 32'h1, {31'h0, lo.link_up});
    rq.sync  <= 1'b1;
    rq.an_en <= 1'b1;
    repeat (3) strobe(1'b0, 1'b0, 16'h01A0);
    rd(32'h18, 32'h5, "an able");
    rq.an_en <= 1'b0;
    tick(3);
    rd(32'h18, 32'h4, "an able off");
    bus(1'b1, 32'h40, 32'h6C00);
    rq.tx_active <= 1'b1;
    rq.rx_ext    <= 1'b1;
    rq.rx_ext_err <= 1'b1;
    tick(3);
    chk("crs half", 32'h1, {31'h0, lo.crs});
    chk("rx_ext half", 32'h1, {31'h0, lo.rx_ext});
    chk("rx_ext_err half", 32'h1, {31'h0, lo.rx_ext_err});
    rq.full_dup <= 1'b1;
    tick(3);
    chk("crs full", 32'h0, {31'h0, lo.crs});
    chk("rx_ext full", 32'h0, {31'h0, lo.rx_ext});
    chk("rx_ext_err full", 32'h0, {31'h0, lo.rx_ext_err});
    rq.mode    <= 2'h2;
    rq.link_ok <= 1'b1;
    tick(3);
    strobe(1'b1, 1'b0, 16'h8001);
    rd(32'h18, 32'h6, "expansion sgmii");
    rd(32'h40, 32'h6C02, "ctrl mode");
    chk("np_word sgmii", 32'h0, {16'h0, lo.np_word});
    rq.mode <= FANP_MODE_FX;
    tick(3);
    rd(32'h3C, 32'h0, "ext_stat fx");
    rq.mode <= FANP_MODE_1000X;
    sw_rst  <= 1'b1;
    tick(1);
    sw_rst <= 1'b0;
    tick(3);
    rd(32'h1C, 32'h2001, "np_tx swrst");
    rd(32'h18, 32'h4, "expansion swrst");
    rd(32'h40, 32'h6C01, "ctrl swrst");
    final_report;
  end
endmodule : fanp_regs_tb_top

`default_nettype wire

// ---- verilog/fanp_regs.sv ----
// Fiber next-page register bank with an AHB-Lite slave port.
// Assumes the link inputs are synchronous to i_core_clk and that the
// negotiation engine outside reports pages as one-cycle strobes.
`timescale 1ns/100ps
`default_nettype none

module fanp_regs (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_sw_rst,
  input  wire logic                    i_hsel,
  input  wire logic [31:0]             i_haddr,
  input  wire logic [1:0]              i_htrans,
  input  wire logic                    i_hwrite,
  input  wire logic [2:0]              i_hsize,
  input  wire logic [31:0]             i_hwdata,
  input  wire logic                    i_hready,
  output var  logic [31:0]             o_hrdata,
  output var  logic                    o_hreadyout,
  output var  logic                    o_hresp,
  input  wire fanp_pkg::fanp_link_in_s i_link,
  output var  fanp_pkg::fanp_link_out_s o_link
);
  import fanp_pkg::*;

  typedef struct packed {
    logic [1:0]     mode;
    logic           lp_np_able;
    logic           page_rx;
    logic           lp_an_able;
    logic [1:0]     match_cnt;
    logic [15:0]    last_cfg;
    logic [15:0]    np_tx;
    logic [15:0]    lp_np;
    logic [15:0]    ctrl;
    logic           wr_pend;
    logic [5:0]     wr_idx;
    logic [15:0]    rdata;
    fanp_link_out_s lo;
  } fanp_state_s;

  localparam fanp_state_s FANP_STATE_RST = '{
    mode:       FANP_MODE_FX,
    lp_np_able: 1'b0,
    page_rx:    1'b0,
    lp_an_able: 1'b0,
    match_cnt:  2'h0,
    last_cfg:   16'h0000,
    np_tx:      FANP_NP_TX_RST,
    lp_np:      16'h0000,
    ctrl:       FANP_CTRL_RST,
    wr_pend:    1'b0,
    wr_idx:     6'h00,
    rdata:      16'h0000,
    lo:         '0
  };

  fanp_state_s s_q;
  fanp_state_s s_d;

  function automatic logic is_1000x(input logic [1:0] mode);
    is_1000x = (mode == FANP_MODE_1000X);
  endfunction : is_1000x

  logic        acc_ok;
  logic        rd_acc;
  logic [5:0]  acc_idx;
  logic        link_eff;
  logic        base_page;
  logic        next_page;
  logic [15:0] expansion;
  logic [15:0] ext_stat;
  logic [15:0] ctrl_view;
  logic [15:0] wdata;

  assign acc_ok  = i_hsel && i_hready &&
                   (i_htrans == FANP_HTRANS_NONSEQ ||
                    i_htrans == FANP_HTRANS_SEQ);
  assign rd_acc  = acc_ok && !i_hwrite;
  assign acc_idx = i_haddr[7:2];
  assign wdata   = i_hwdata[15:0];

  // Link as seen by software; forcing bypasses the link machine
  assign link_eff  = s_q.ctrl[FANP_CTRL_FORCE] | i_link.link_ok;
  assign base_page = i_link.page_valid && !i_link.page_next;
  assign next_page = i_link.page_valid && i_link.page_next;

  // Bit 2 is hard wired, bits 15:4 read zero
  assign expansion = {12'h000, s_q.lp_np_able, 1'b1,
                      s_q.page_rx, s_q.lp_an_able};
  assign ext_stat  = {{2{s_q.mode != FANP_MODE_FX}}, 14'h0000};
  assign ctrl_view = {s_q.ctrl[15:9], 7'h00, s_q.mode};

  always_comb begin
    s_d = s_q;
    s_d.mode = i_link.mode;
    s_d.lo.np_loaded = 1'b0;

    // Data phase of a write accepted in the previous cycle
    if (s_q.wr_pend) begin
      case (s_q.wr_idx)
        FANP_IDX_NP_TX: begin
          s_d.np_tx = (s_q.np_tx & ~FANP_NP_TX_WMASK) |
                      (wdata & FANP_NP_TX_WMASK);
          s_d.lo.np_loaded = is_1000x(s_q.mode);
        end
        // Bits 8:0 are masked to zero as written; only bits 15:9 are stored
        FANP_IDX_CTRL_ONE: begin
          s_d.ctrl = wdata & FANP_CTRL_WMASK;
        end
        default: begin
          s_d.ctrl = s_d.ctrl;
        end
      endcase
    end

    // Toggle follows every received page, never the bus
    if (i_link.page_valid) begin
      s_d.np_tx[FANP_TOGGLE_BIT] = ~s_q.np_tx[FANP_TOGGLE_BIT];
    end

    // Latching flag: a page in the read cycle survives the clear
    if (rd_acc && acc_idx == FANP_IDX_EXPANSION) begin
      s_d.page_rx = i_link.page_valid;
    end else if (i_link.page_valid) begin
      s_d.page_rx = 1'b1;
    end

    if (!link_eff) begin
      s_d.lp_np_able = 1'b0;
      s_d.lp_np = 16'h0000;
    end else if (is_1000x(s_q.mode)) begin
      if (base_page && i_link.page_word[FANP_NP_BIT]) begin
        s_d.lp_np_able = 1'b1;
      end
      if (next_page) begin
        s_d.lp_np = i_link.page_word;
      end
    end
    // New mode applies at once so the bit never lags a mode change
    if (!is_1000x(s_d.mode)) begin
      s_d.lp_np_able = 1'b0;
    end

    // Three matching non-zero code groups in a row
    if (!i_link.sync) begin
      s_d.match_cnt = 2'h0;
    end else if (i_link.cfg_valid) begin
      s_d.last_cfg = i_link.cfg_word;
      if (i_link.cfg_word == 16'h0000) begin
        s_d.match_cnt = 2'h0;
      end else if (i_link.cfg_word != s_q.last_cfg ||
                   s_q.match_cnt == 2'h0) begin
        s_d.match_cnt = 2'h1;
      end else if (s_q.match_cnt != FANP_MATCH_NEED) begin
        s_d.match_cnt = s_q.match_cnt + 2'h1;
      end
    end
    s_d.lp_an_able = i_link.sync && i_link.an_en &&
                     (s_q.match_cnt == FANP_MATCH_NEED);

    // Address phase; read data registered for the data phase
    s_d.wr_pend = acc_ok && i_hwrite;
    s_d.wr_idx  = acc_idx;
    if (rd_acc) begin
      case (acc_idx)
        FANP_IDX_EXPANSION: s_d.rdata = expansion;
        FANP_IDX_NP_TX:     s_d.rdata = s_q.np_tx;
        FANP_IDX_LP_NP:     s_d.rdata = s_q.lp_np;
        FANP_IDX_EXT_STAT:  s_d.rdata = ext_stat;
        FANP_IDX_CTRL_ONE:  s_d.rdata = ctrl_view;
        default:            s_d.rdata = 16'h0000;
      endcase
    end

    // Link-facing outputs, one register stage
    s_d.lo.link_up = link_eff;
    s_d.lo.crs = s_q.ctrl[FANP_CTRL_CRS_TX] && !i_link.full_dup &&
                 i_link.tx_active;
    s_d.lo.rx_ext = i_link.rx_ext &&
                    !(s_q.ctrl[FANP_CTRL_BLK_EXT] && i_link.full_dup);
    s_d.lo.rx_ext_err = i_link.rx_ext_err &&
                        !(s_q.ctrl[FANP_CTRL_BLK_EXT] && i_link.full_dup);
    // Only 1000BASE-X sends the page; other modes see zero
    s_d.lo.np_word = is_1000x(s_q.mode) ? s_d.np_tx : 16'h0000;

    // Software reset: status and pages reset, marked control bits kept
    if (i_sw_rst) begin
      s_d.lp_np_able = 1'b0;
      s_d.page_rx    = 1'b0;
      s_d.lp_an_able = 1'b0;
      s_d.match_cnt  = 2'h0;
      s_d.np_tx      = FANP_NP_TX_RST;
      s_d.lp_np      = 16'h0000;
      s_d.ctrl       = s_d.ctrl & FANP_CTRL_RETAIN;
      s_d.lo.np_loaded = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= FANP_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero wait states; every access answers OKAY
  always_comb begin
    o_hrdata    = {16'h0000, s_q.rdata};
    o_hreadyout = 1'b1;
    o_hresp     = 1'b0;
    o_link      = s_q.lo;
  end

  a_lp_np_mode: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !is_1000x(s_q.mode) |-> !s_q.lp_np_able)
    else $error("partner next page bit set outside 1000BASE-X");

  a_lp_np_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (link_eff && is_1000x(s_q.mode) && i_link.mode == s_q.mode && !i_sw_rst
     && base_page && i_link.page_word[FANP_NP_BIT]) |=> s_q.lp_np_able)
    else $error("partner next page bit not set by base page");

  a_link_clr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !link_eff |=> (!s_q.lp_np_able && s_q.lp_np == 16'h0000))
    else $error("link down did not clear partner page state");

  a_page_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_link.page_valid && !i_sw_rst) |=> s_q.page_rx)
    else $error("received page lost");

  a_page_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (rd_acc && acc_idx == FANP_IDX_EXPANSION && !i_link.page_valid)
    |=> (!s_q.page_rx && s_q.rdata[1] == $past(s_q.page_rx)))
    else $error("expansion read did not clear page flag");

  a_an_able: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_q.lp_an_able |-> ($past(i_link.sync) && $past(i_link.an_en)))
    else $error("negotiation capable without sync or enable");

  a_np_loaded: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (acc_ok && i_hwrite && acc_idx == FANP_IDX_NP_TX)
    ##1 (is_1000x(s_q.mode) && !i_sw_rst) |=> o_link.np_loaded)
    else $error("next page write did not flag loaded page");

  a_np_fx_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_link.np_loaded |-> is_1000x($past(s_q.mode)))
    else $error("next page loaded outside 1000BASE-X");

  a_toggle_flip: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_link.page_valid && !i_sw_rst) |=>
    s_q.np_tx[FANP_TOGGLE_BIT] != $past(s_q.np_tx[FANP_TOGGLE_BIT]))
    else $error("toggle did not invert on received page");

  a_ext_stat: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ext_stat[13:0] == 14'h0000 &&
    ext_stat[15] == (s_q.mode != FANP_MODE_FX))
    else $error("extended status bits wrong");

  a_crs_tx: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_link.crs |-> ($past(i_link.tx_active) && !$past(i_link.full_dup)))
    else $error("carrier sense asserted outside half duplex transmit");

  a_blk_ext: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (s_q.ctrl[FANP_CTRL_BLK_EXT] && i_link.full_dup) |=> !o_link.rx_ext)
    else $error("carrier extension passed in full duplex");

  a_force_link: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_q.ctrl[FANP_CTRL_FORCE] |=> o_link.link_up)
    else $error("forced link not reported up");

  a_lp_np_newmode: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    !is_1000x(i_link.mode) |=> !s_q.lp_np_able)
    else $error("partner next page bit kept after mode change");

  a_lp_np_rise: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    $rose(s_q.lp_np_able) |->
    $past(base_page && i_link.page_word[FANP_NP_BIT]))
    else $error("partner next page bit set without base page");

  a_lp_np_fall: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    $fell(s_q.lp_np_able) |->
    (!$past(link_eff) || !is_1000x(s_q.mode) || $past(i_sw_rst)))
    else $error("partner next page bit dropped without cause");

  a_local_np: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    expansion[2] && expansion[15:4] == 12'h000)
    else $error("expansion fixed bits wrong");

  a_page_rise: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    $rose(s_q.page_rx) |-> $past(i_link.page_valid))
    else $error("page flag set without a page");

  a_page_keep: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (s_q.page_rx && !i_sw_rst &&
     !(rd_acc && acc_idx == FANP_IDX_EXPANSION)) |=> s_q.page_rx)
    else $error("page flag cleared without a read");

  a_an_rise: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    $rose(s_q.lp_an_able) |-> $past(s_q.match_cnt == FANP_MATCH_NEED))
    else $error("negotiation capable before three matches");

  a_np_load_src: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    o_link.np_loaded |->
    $past(s_q.wr_pend && s_q.wr_idx == FANP_IDX_NP_TX))
    else $error("page loaded without a transmit write");

  a_np_word_quiet: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    !is_1000x($past(s_q.mode)) |-> o_link.np_word == 16'h0000)
    else $error("next page word sent outside 1000BASE-X");

  a_np_word_src: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (is_1000x($past(s_q.mode)) && !$past(i_sw_rst)) |->
    o_link.np_word == s_q.np_tx)
    else $error("sent next page word differs from register");

  a_np_tx_bit14: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    !s_q.np_tx[14])
    else $error("read-only transmit bit 14 set");

  a_toggle_hold: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (!i_link.page_valid && !i_sw_rst) |=>
    $stable(s_q.np_tx[FANP_TOGGLE_BIT]))
    else $error("toggle changed without a received page");

  a_lp_np_load: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (link_eff && is_1000x(s_q.mode) && next_page && !i_sw_rst) |=>
    s_q.lp_np == $past(i_link.page_word))
    else $error("partner next page not loaded");

  a_lp_np_keep: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (link_eff && !next_page && !i_sw_rst) |=> $stable(s_q.lp_np))
    else $error("partner next page changed without a page");

  a_ext_half: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    ext_stat[14] == (s_q.mode != FANP_MODE_FX))
    else $error("half duplex capability bit wrong");

  a_ext_pass: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (i_link.rx_ext && i_link.rx_ext_err && !i_link.full_dup) |=>
    (o_link.rx_ext && o_link.rx_ext_err))
    else $error("carrier extension blocked in half duplex");

  a_ext_err_blk: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (s_q.ctrl[FANP_CTRL_BLK_EXT] && i_link.full_dup) |=>
    !o_link.rx_ext_err)
    else $error("extension with error passed in full duplex");

  a_crs_on: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (s_q.ctrl[FANP_CTRL_CRS_TX] && !i_link.full_dup &&
     i_link.tx_active) |=> o_link.crs)
    else $error("carrier sense missing on half duplex transmit");

  a_link_follow: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    !s_q.ctrl[FANP_CTRL_FORCE] |=> o_link.link_up == $past(i_link.link_ok))
    else $error("link status does not follow link machine");

  a_ctrl_low: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    s_q.ctrl[8:0] == 9'h000)
    else $error("control low bits stored");

  a_mode_mirror: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    $past(i_rst_n) |-> s_q.mode == $past(i_link.mode))
    else $error("mode field does not mirror fiber mode");

  a_sw_rst_pages: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    i_sw_rst |=> (s_q.np_tx == FANP_NP_TX_RST &&
                  s_q.lp_np == 16'h0000 && !s_q.page_rx))
    else $error("software reset left page state");

endmodule : fanp_regs

`default_nettype wire
